// *** rtl/bpc_map.svh ***
// pin widths, field positions and drive constants for the bus pin control
`ifndef BPC_MAP_SVH
`define BPC_MAP_SVH

`define BPC_ADDR_W    25
`define BPC_DATA_W    16
`define BPC_CAS_W     3
`define BPC_CAS_LSB   15
`define BPC_CAS_MSB   17
`define BPC_ADDR_HIGH 25'h1FFFFFF
`define BPC_DATA_ZERO 16'h0000
`define BPC_LANE_W    8

`endif

// *** rtl/bpc_phase_clk.sv ***
// first-phase clock divider driving the phase clock pin
`timescale 1ns/100ps

module bpc_phase_clk (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic powerdown_mode,
    output logic      phase_clock_out
);

    logic phase;
    logic next_phase;
    logic next_out;

    // half the double-rate input; keeps running through hold and idle
    always_comb
    begin
        next_phase = ~phase;
        next_out   = powerdown_mode ? 1'b0 : next_phase;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            phase           <= 1'b0;
            phase_clock_out <= 1'b0;
        end
        else
        begin
            phase           <= next_phase;
            phase_clock_out <= next_out;
        end
    end

endmodule

// *** rtl/bpc_pins.sv ***
// bus status pin control: cycle sequencer and mode-dependent pin states
`timescale 1ns/100ps
`include "bpc_map.svh"

module bpc_pins (
    input  wire logic                     clk,
    input  wire logic                     nrst,
    input  wire logic                     req_valid,
    input  wire logic [`BPC_ADDR_W-1:0]   req_addr,
    input  wire logic                     req_upper,
    input  wire logic                     req_lower,
    input  wire logic                     req_write,
    input  wire logic                     req_data_ctl,
    input  wire logic                     req_mem_io,
    input  wire logic                     req_inta,
    input  wire logic [`BPC_CAS_W-1:0]    req_slave_id,
    input  wire logic [`BPC_DATA_W-1:0]   req_wdata,
    output logic                          req_ready,
    output logic                          done,
    output logic [`BPC_DATA_W-1:0]        rdata,
    input  wire logic                     bus_ready_n,
    input  wire logic                     narrow_port_n,
    input  wire logic                     coproc_busy_n,
    input  wire logic                     selftest_done,
    output logic                          selftest_run,
    input  wire logic                     hold_grant,
    input  wire logic                     idle_mode,
    input  wire logic                     powerdown_mode,
    input  wire logic                     float_request_n,
    input  wire logic                     im_owns_bus,
    input  wire logic [`BPC_ADDR_W-1:0]   im_address,
    input  wire logic                     im_strobe_n,
    input  wire logic                     im_upper_n,
    input  wire logic                     im_lower_n,
    output logic [`BPC_ADDR_W-1:0]        address_lines,
    output logic                          address_oe,
    output logic                          address_strobe_n,
    output logic                          address_strobe_oe,
    output logic                          upper_byte_sel_n,
    output logic                          upper_byte_sel_oe,
    output logic                          lower_byte_sel_n,
    output logic                          lower_byte_sel_oe,
    output logic                          write_read,
    output logic                          data_ctl,
    output logic                          mem_io,
    output logic                          cycle_def_oe,
    output logic [`BPC_DATA_W-1:0]        data_lines_out,
    output logic                          data_lines_oe,
    input  wire logic [`BPC_DATA_W-1:0]   data_lines_in,
    output logic                          phase_clock_out,
    output logic                          phase_clock_oe
);

    // cycle state
    bpc_pkg::bpc_state_e               state;
    bpc_pkg::bpc_state_e               next_state;
    logic [`BPC_ADDR_W-1:0]            cur_addr;
    logic [`BPC_ADDR_W-1:0]            next_cur_addr;
    logic                              cur_upper;
    logic                              next_cur_upper;
    logic                              cur_lower;
    logic                              next_cur_lower;
    logic                              cur_write;
    logic                              next_cur_write;
    logic                              cur_dc;
    logic                              next_cur_dc;
    logic                              cur_mio;
    logic                              next_cur_mio;
    logic                              cur_inta;
    logic                              next_cur_inta;
    logic [`BPC_CAS_W-1:0]             cur_slave;
    logic [`BPC_CAS_W-1:0]             next_cur_slave;
    logic [`BPC_DATA_W-1:0]            cur_wdata;
    logic [`BPC_DATA_W-1:0]            next_cur_wdata;
    logic                              split_half;
    logic                              next_split_half;
    logic                              next_req_ready;
    logic                              next_done;
    logic [`BPC_DATA_W-1:0]            next_rdata;
    bpc_pkg::bpc_mode_e                mode;
    logic                              bus_free;
    logic                              take;

    // pin next values
    logic [`BPC_ADDR_W-1:0]            next_address;
    logic                              next_address_oe;
    logic                              next_strobe_n;
    logic                              next_upper_n;
    logic                              next_lower_n;
    logic                              next_sel_oe;
    logic                              next_write_read;
    logic                              next_data_ctl;
    logic                              next_mem_io;
    logic                              next_data_oe;
    logic                              next_pclk_oe;

    // active-low lane select for a pending byte
    function automatic logic sel_n(input logic moves);
        sel_n = ~moves;
    endfunction

    // address with the cascade field substituted on acknowledge cycles
    function automatic logic [`BPC_ADDR_W-1:0] cyc_addr(
        input logic [`BPC_ADDR_W-1:0] a,
        input logic                   inta,
        input logic [`BPC_CAS_W-1:0]  id);
        cyc_addr = a;
        if (inta)
            cyc_addr[`BPC_CAS_MSB:`BPC_CAS_LSB] = id;
    endfunction

    bpc_selftest u_selftest (
        .clk           (clk),
        .nrst          (nrst),
        .coproc_busy_n (coproc_busy_n),
        .selftest_done (selftest_done),
        .selftest_run  (selftest_run)
    );

    bpc_phase_clk u_phase (
        .clk             (clk),
        .nrst            (nrst),
        .powerdown_mode  (powerdown_mode),
        .phase_clock_out (phase_clock_out)
    );

    // mode priority: async reset above all, then float, hold, powerdown
    always_comb
    begin
        if (!float_request_n)
            mode = bpc_pkg::BPC_M_FLOAT;
        else if (hold_grant)
            mode = bpc_pkg::BPC_M_HOLD;
        else if (powerdown_mode)
            mode = bpc_pkg::BPC_M_PDOWN;
        else if (idle_mode && !im_owns_bus)
            mode = bpc_pkg::BPC_M_IDLE;
        else if (im_owns_bus)
            mode = bpc_pkg::BPC_M_IMAST;
        else
            mode = bpc_pkg::BPC_M_RUN;
    end

    // self test holds off bus cycles only from the second edge after release
    assign bus_free = (mode == bpc_pkg::BPC_M_RUN) && !selftest_run;
    assign take     = bus_free && req_valid;

    // cycle sequencer
    always_comb
    begin
        next_state      = state;
        next_cur_addr   = cur_addr;
        next_cur_upper  = cur_upper;
        next_cur_lower  = cur_lower;
        next_cur_write  = cur_write;
        next_cur_dc     = cur_dc;
        next_cur_mio    = cur_mio;
        next_cur_inta   = cur_inta;
        next_cur_slave  = cur_slave;
        next_cur_wdata  = cur_wdata;
        next_split_half = split_half;
        next_done       = 1'b0;
        next_rdata      = rdata;
        next_req_ready  = 1'b0;
        case (state)
            bpc_pkg::BPC_IDLE:
            begin
                if (take)
                    next_state = bpc_pkg::BPC_FIRST;
            end
            bpc_pkg::BPC_FIRST:
            begin
                next_state = bpc_pkg::BPC_SECOND;
            end
            default:
            begin
                if (!bus_ready_n)
                begin
                    // narrow device: rerun upper byte on the low lane
                    if (!narrow_port_n && cur_upper && cur_lower
                        && !split_half)
                    begin
                        // low byte is final here; the rerun fills the top
                        next_rdata      = data_lines_in;
                        next_cur_lower  = 1'b0;
                        next_split_half = 1'b1;
                        next_state      = bpc_pkg::BPC_FIRST;
                    end
                    else
                    begin
                        if (split_half)
                            next_rdata[`BPC_DATA_W-1:`BPC_LANE_W] =
                                data_lines_in[`BPC_LANE_W-1:0];
                        else
                            next_rdata = data_lines_in;
                        next_done  = 1'b1;
                        next_state = take ? bpc_pkg::BPC_FIRST
                                          : bpc_pkg::BPC_IDLE;
                    end
                end
            end
        endcase
        if ((state != bpc_pkg::BPC_FIRST) && take
            && (next_state == bpc_pkg::BPC_FIRST) && !next_split_half)
        begin
            next_req_ready  = 1'b1;
            next_cur_addr   = req_addr;
            next_cur_upper  = req_upper;
            next_cur_lower  = req_lower;
            next_cur_write  = req_write;
            next_cur_dc     = req_data_ctl;
            next_cur_mio    = req_mem_io;
            next_cur_inta   = req_inta;
            next_cur_slave  = req_slave_id;
            next_cur_wdata  = req_wdata;
        end
        if (next_state == bpc_pkg::BPC_IDLE)
            next_split_half = 1'b0;
        else if (next_req_ready)
            next_split_half = 1'b0;
    end

    // pin states by mode; registered so every pin leaves a flip-flop
    always_comb
    begin
        next_address    = address_lines;
        next_address_oe = 1'b1;
        next_strobe_n   = 1'b1;
        next_upper_n    = upper_byte_sel_n;
        next_lower_n    = lower_byte_sel_n;
        next_sel_oe     = 1'b1;
        next_write_read = write_read;
        next_data_ctl   = data_ctl;
        next_mem_io     = mem_io;
        next_data_oe    = 1'b0;
        next_pclk_oe    = 1'b1;
        case (mode)
            bpc_pkg::BPC_M_FLOAT:
            begin
                next_address_oe = 1'b0;
                next_sel_oe     = 1'b0;
                next_pclk_oe    = 1'b0;
            end
            bpc_pkg::BPC_M_HOLD:
            begin
                next_address_oe = 1'b0;
                next_sel_oe     = 1'b0;
            end
            bpc_pkg::BPC_M_PDOWN:
            begin
                next_address = `BPC_ADDR_HIGH;
                next_upper_n = 1'b0;
                next_lower_n = 1'b1;
            end
            bpc_pkg::BPC_M_IDLE:
            begin
                next_address = `BPC_ADDR_HIGH;
            end
            bpc_pkg::BPC_M_IMAST:
            begin
                next_address  = im_address;
                next_strobe_n = im_strobe_n;
                next_upper_n  = im_upper_n;
                next_lower_n  = im_lower_n;
            end
            default:
            begin
                if (next_state == bpc_pkg::BPC_FIRST)
                begin
                    // address and definition change only at a first state
                    next_address    = cyc_addr(next_cur_addr,
                                               next_cur_inta,
                                               next_cur_slave);
                    next_upper_n    = sel_n(next_cur_upper);
                    next_lower_n    = sel_n(next_cur_lower);
                    next_write_read = next_cur_write;
                    next_data_ctl   = next_cur_dc;
                    next_mem_io     = next_cur_mio;
                    next_strobe_n   = 1'b0;
                end
                next_data_oe = (next_state == bpc_pkg::BPC_SECOND
                                && next_cur_write)
                            || (state == bpc_pkg::BPC_SECOND
                                && cur_write);
            end
        endcase
    end

    // reset states take a constant regardless of any other mode
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state             <= bpc_pkg::BPC_IDLE;
            cur_addr          <= `BPC_ADDR_HIGH;
            cur_upper         <= 1'b0;
            cur_lower         <= 1'b0;
            cur_write         <= 1'b0;
            cur_dc            <= 1'b0;
            cur_mio           <= 1'b0;
            cur_inta          <= 1'b0;
            cur_slave         <= '0;
            cur_wdata         <= `BPC_DATA_ZERO;
            split_half        <= 1'b0;
            req_ready         <= 1'b0;
            done              <= 1'b0;
            rdata             <= `BPC_DATA_ZERO;
            address_lines     <= `BPC_ADDR_HIGH;
            address_oe        <= 1'b1;
            address_strobe_n  <= 1'b1;
            address_strobe_oe <= 1'b1;
            upper_byte_sel_n  <= 1'b0;
            lower_byte_sel_n  <= 1'b0;
            upper_byte_sel_oe <= 1'b1;
            lower_byte_sel_oe <= 1'b1;
            write_read        <= 1'b0;
            data_ctl          <= 1'b1;
            mem_io            <= 1'b0;
            cycle_def_oe      <= 1'b1;
            data_lines_out    <= `BPC_DATA_ZERO;
            data_lines_oe     <= 1'b0;
            phase_clock_oe    <= 1'b1;
        end
        else
        begin
            state             <= next_state;
            cur_addr          <= next_cur_addr;
            cur_upper         <= next_cur_upper;
            cur_lower         <= next_cur_lower;
            cur_write         <= next_cur_write;
            cur_dc            <= next_cur_dc;
            cur_mio           <= next_cur_mio;
            cur_inta          <= next_cur_inta;
            cur_slave         <= next_cur_slave;
            cur_wdata         <= next_cur_wdata;
            split_half        <= next_split_half;
            req_ready         <= next_req_ready;
            done              <= next_done;
            rdata             <= next_rdata;
            address_lines     <= next_address;
            address_oe        <= next_address_oe;
            address_strobe_n  <= next_strobe_n;
            address_strobe_oe <= next_address_oe;
            upper_byte_sel_n  <= next_upper_n;
            lower_byte_sel_n  <= next_lower_n;
            upper_byte_sel_oe <= next_sel_oe;
            lower_byte_sel_oe <= next_sel_oe;
            write_read        <= next_write_read;
            data_ctl          <= next_data_ctl;
            mem_io            <= next_mem_io;
            cycle_def_oe      <= next_sel_oe;
            // split upper byte rides the low lane
            data_lines_out    <= next_split_half
                ? {next_cur_wdata[`BPC_DATA_W-1:`BPC_LANE_W],
                   next_cur_wdata[`BPC_DATA_W-1:`BPC_LANE_W]}
                : next_cur_wdata;
            data_lines_oe     <= next_data_oe && float_request_n;
            phase_clock_oe    <= next_pclk_oe;
        end
    end

    sequence s_hold_seen;
        hold_grant && float_request_n;
    endsequence

    sequence s_strobe_low;
        !address_strobe_n && address_strobe_oe;
    endsequence

    AST_HOLD_FLOATS: assert property (@(posedge clk) disable iff (!nrst)
        s_hold_seen |=> !address_oe && !upper_byte_sel_oe
                        && !lower_byte_sel_oe && !address_strobe_oe)
        else $error("pins not floated in hold");

    AST_ADDR_FLOAT: assert property (@(posedge clk) disable iff (!nrst)
        hold_grant |=> !address_oe)
        else $error("address not floated in hold");

    AST_FLOAT_ALL: assert property (@(posedge clk) disable iff (!nrst)
        !float_request_n |=> !address_oe && !phase_clock_oe
                             && !data_lines_oe && !cycle_def_oe)
        else $error("float request not honoured");

    AST_PDOWN_PINS: assert property (@(posedge clk) disable iff (!nrst)
        powerdown_mode && !hold_grant && float_request_n |=>
            !upper_byte_sel_n && lower_byte_sel_n && address_strobe_n
            && (address_lines == `BPC_ADDR_HIGH))
        else $error("powerdown pin states wrong");

    AST_IDLE_HIGH: assert property (@(posedge clk) disable iff (!nrst)
        idle_mode && !im_owns_bus && !powerdown_mode && !hold_grant
        && float_request_n |=> address_strobe_n
                               && (address_lines == `BPC_ADDR_HIGH))
        else $error("idle address not high");

    AST_IDLE_KEEP: assert property (@(posedge clk) disable iff (!nrst)
        idle_mode && !im_owns_bus && !powerdown_mode && !hold_grant
        && float_request_n |=> $stable(upper_byte_sel_n)
                               && $stable(lower_byte_sel_n))
        else $error("idle byte selects changed");

    AST_PCLK_LOW: assert property (@(posedge clk) disable iff (!nrst)
        powerdown_mode [*2] |-> !phase_clock_out)
        else $error("phase clock runs in powerdown");

    // first edge out of powerdown may keep the low level for phase alignment
    AST_PCLK_RUN: assert property (@(posedge clk) disable iff (!nrst)
        !powerdown_mode [*3] |-> phase_clock_out != $past(phase_clock_out))
        else $error("phase clock stopped");

    AST_STROBE_DEF: assert property (@(posedge clk) disable iff (!nrst)
        s_strobe_low and (state == bpc_pkg::BPC_FIRST) |->
            cycle_def_oe && address_oe && !(upper_byte_sel_n
                                             && lower_byte_sel_n))
        else $error("strobe without full cycle definition");

    AST_ADDR_HOLD: assert property (@(posedge clk) disable iff (!nrst)
        (state == bpc_pkg::BPC_SECOND) && (mode == bpc_pkg::BPC_M_RUN)
        ##1 (state == bpc_pkg::BPC_SECOND) && (mode == bpc_pkg::BPC_M_RUN)
        |-> $stable(address_lines))
        else $error("address moved inside a cycle");

    AST_SELFTEST_GATE: assert property (@(posedge clk) disable iff (!nrst)
        selftest_run |=> !req_ready)
        else $error("cycle started during self test");

endmodule

// *** rtl/bpc_pkg.sv ***
// types shared by the bus pin control block
package bpc_pkg;

    // gray codes along idle -> first -> second
    typedef enum logic [1:0] {
        BPC_IDLE   = 2'h0,
        BPC_FIRST  = 2'h1,
        BPC_SECOND = 2'h3
    } bpc_state_e;

    // pin drive mode, highest priority first, except that BPC_M_IMAST outranks BPC_M_IDLE
    typedef enum logic [2:0] {
        BPC_M_FLOAT = 3'h0,
        BPC_M_HOLD  = 3'h1,
        BPC_M_PDOWN = 3'h2,
        BPC_M_IDLE  = 3'h3,
        BPC_M_IMAST = 3'h4,
        BPC_M_RUN   = 3'h5
    } bpc_mode_e;

endpackage

// *** rtl/bpc_selftest.sv ***
// catches the coprocessor busy level at reset release for self test
`timescale 1ns/100ps

module bpc_selftest (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic coproc_busy_n,
    input  wire logic selftest_done,
    output logic      selftest_run
);

    logic caught;
    logic next_caught;
    logic next_run;

    // a strap cannot be loaded by the async reset, so it is taken
    // on the first clock edge after release
    always_comb
    begin
        next_caught = 1'b1;
        next_run    = selftest_run & ~selftest_done;
        if (!caught)
            next_run = ~coproc_busy_n;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            caught       <= 1'b0;
            selftest_run <= 1'b0;
        end
        else
        begin
            caught       <= next_caught;
            selftest_run <= next_run;
        end
    end

endmodule

// *** tb/bpc_mem_model.sv ***
// far-side memory model that answers bus cycles
`timescale 1ns/100ps

module bpc_mem_model (
    input  wire logic        clk,
    input  wire logic        address_strobe_n,
    input  wire logic        lower_byte_sel_n,
    input  wire logic        narrow,
    input  wire logic        slow,
    output logic             bus_ready_n,
    output logic             narrow_port_n,
    output logic [15:0]      data_lines_in
);
    logic [1:0] cnt = 2'h0;
    logic       tog = 1'b0;

    // slow adds two wait states before ready
    always @(posedge clk)
    begin
        tog <= ~tog;
        if (!address_strobe_n)
            cnt <= slow ? 2'h3 : 2'h1;
        else if (cnt != 2'h0)
            cnt <= cnt - 2'h1;
    end
    assign bus_ready_n   = (cnt != 2'h1);
    assign narrow_port_n = !(narrow && cnt == 2'h1);
    // lanes wiggle off-cycle so a stale value never reads as good data
    assign data_lines_in = (cnt == 2'h1) ?
        {8'h5A, lower_byte_sel_n ? 8'h96 : 8'h3C} : {16{tog}};
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for the bus pin control block
`timescale 1ns/100ps

module tb_top;
    logic clk = 1'b0, nrst = 1'b0, req_valid = 1'b0, req_upper = 1'b1;
    logic req_lower = 1'b1, req_write = 1'b0, req_data_ctl = 1'b1;
    logic req_mem_io = 1'b1, req_inta = 1'b0, coproc_busy_n = 1'b1;
    logic selftest_done = 1'b0, hold_grant = 1'b1, idle_mode = 1'b0;
    logic powerdown_mode = 1'b1, float_request_n = 1'b1, im_owns_bus = 1'b0;
    logic im_strobe_n = 1'b0, im_upper_n = 1'b1, im_lower_n = 1'b0;
    logic narrow = 1'b0, slow = 1'b0, p;
    logic [24:0] req_addr = 25'h0, im_address = 25'h0AAAAAA, address_lines;
    logic [2:0]  req_slave_id = 3'h5;
    logic [15:0] req_wdata = 16'hC0DE, rdata, data_lines_in, data_lines_out;
    logic req_ready, done, bus_ready_n, narrow_port_n, selftest_run;
    logic address_oe, address_strobe_n, address_strobe_oe, upper_byte_sel_n;
    logic upper_byte_sel_oe, lower_byte_sel_n, lower_byte_sel_oe, write_read;
    logic data_ctl, mem_io, cycle_def_oe, data_lines_oe, phase_clock_out;
    logic phase_clock_oe;
    int   fails = 0, checked = 0;

    bpc_pins      i_bpc_pins (.*);
    bpc_mem_model i_bpc_mem_model (.*);

    always #50 clk = ~clk;

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
    begin
        checked++;
        if (g !== e)
        begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    end
    endtask

    task automatic tick(input int n);
    begin
        repeat (n) @(negedge clk);
    end
    endtask

    // bounded wait for req_ready (d=0) or done (d=1)
    task automatic wait_sig(input logic d);
        int n;
    begin
        n = 0;
        while ((d ? done : req_ready) !== 1'b1 && n < 20)
        begin
            tick(1);
            n++;
        end
        if ((d ? done : req_ready) !== 1'b1)
            fails++;
    end
    endtask

    task automatic bus(input logic [24:0] a, input logic w, input logic ia,
                       input logic [15:0] rd);
        logic [24:0] ea;
        logic [4:0]  ed;
    begin
        tick(1);
        {req_addr, req_write, req_inta, req_valid} = {a, w, ia, 1'b1};
        ea = ia ? {a[24:18], req_slave_id, a[14:0]} : a;
        ed = {~req_upper, ~req_lower, w, req_data_ctl, req_mem_io};
        wait_sig(1'b0);
        req_valid = 1'b0;
        chk({address_strobe_n, address_lines}, {1'b0, ea});
        chk({upper_byte_sel_n, lower_byte_sel_n, write_read, data_ctl,
             mem_io}, ed);
        tick(1);
        if (w)
            chk({data_lines_oe, data_lines_out}, {1'b1, req_wdata});
        wait_sig(1'b1);
        chk({done, w ? 16'h0 : rdata}, {1'b1, rd});
        $display("bus test done t=%0t", $time);
    end
    endtask

    // e and msk: toggle, five enables, strobe, upper, lower
    task automatic mode(input logic [4:0] m, input logic [8:0] msk, e,
                        input logic [24:0] ea);
    begin
        tick(1);
        {hold_grant, powerdown_mode, idle_mode} = m[4:2];
        {im_owns_bus, float_request_n} = m[1:0];
        tick(2);
        p = phase_clock_out;
        tick(1);
        chk({p ^ phase_clock_out, address_oe, address_strobe_oe,
             upper_byte_sel_oe, lower_byte_sel_oe, phase_clock_oe,
             address_strobe_n, upper_byte_sel_n, lower_byte_sel_n} & msk, e);
        chk(address_lines & {25{address_oe}}, ea);
        $display("mode test done t=%0t", $time);
    end
    endtask

    task automatic tally_and_finish;
    begin
        $display("counts: checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask

    initial
    begin
        tick(15);
        chk({address_strobe_n, upper_byte_sel_n, lower_byte_sel_n}, 3'h4);
        chk(address_lines, 25'h1FFFFFF);
        {hold_grant, powerdown_mode} = 2'h0;
        tick(1);
        nrst = 1'b1;
        $display("reset test done t=%0t", $time);
        bus(25'h1234567, 1'b1, 1'b0, 16'h0);
        slow = 1'b1;
        bus(25'h0ABCDEF, 1'b0, 1'b1, 16'h5A3C);
        {slow, narrow} = 2'h1;
        bus(25'h0000010, 1'b0, 1'b0, 16'h963C);
        narrow = 1'b0;
        mode(5'b01001, 9'h1FF, 9'h0FD, 25'h1FFFFFF);
        mode(5'b10001, 9'h1F8, 9'h108, 25'h0);
        mode(5'b00000, 9'h0F8, 9'h000, 25'h0);
        float_request_n = 1'b1;
        bus(25'h1000001, 1'b1, 1'b0, 16'h0);
        mode(5'b00101, 9'h1FF, 9'h1FC, 25'h1FFFFFF);
        mode(5'b00111, 9'h0FF, 9'h0FA, 25'h0AAAAAA);
        nrst = 1'b0;
        {idle_mode, im_owns_bus, coproc_busy_n} = 3'h0;
        tick(2);
        nrst = 1'b1;
        tick(2);
        req_valid = 1'b1;
        tick(4);
        chk({selftest_run, address_strobe_n}, 2'h3);
        {req_valid, selftest_done} = 2'h1;
        tick(1);
        selftest_done = 1'b0;
        $display("self test done t=%0t", $time);
        bus(25'h0000200, 1'b0, 1'b0, 16'h5A3C);
        tally_and_finish();
    end

    // whole run is under a hundred cycles; this margin only cuts a hang
    initial
    begin
        tick(3000);
        fails++;
        tally_and_finish();
    end
endmodule
